// File: logic/eew_axil.sv
// AXI4-Lite slave front end: one write and one read in flight
// assumes the owner decodes addresses combinationally
`timescale 1ns/1ps
module eew_axil
  import eew_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             wr_stb,
  output logic [7:0]       wr_addr,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_ok,
  output logic [7:0]       rd_addr,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_ok
);

  logic aw_have_q;
  logic w_have_q;
  logic rd_stb_q;

  // write path: address and data in either order, then one strobe
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      awready   <= 1'b1;
      wready    <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      wr_stb    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= EEW_RESP_OKAY;
      wr_addr   <= 8'h00;
      wr_data   <= 32'h00000000;
      wr_strb   <= 4'h0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        wr_addr   <= awaddr;
        awready   <= 1'b0;
        aw_have_q <= 1'b1;
      end
      if (wvalid && wready)
      begin
        wr_data  <= wdata;
        wr_strb  <= wstrb;
        wready   <= 1'b0;
        w_have_q <= 1'b1;
      end
      wr_stb <= aw_have_q && w_have_q && !wr_stb && !bvalid;
      if (wr_stb)
      begin
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? EEW_RESP_OKAY : EEW_RESP_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q  <= 1'b0;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // read path: registered answer one cycle after address capture
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      arready  <= 1'b1;
      rd_stb_q <= 1'b0;
      rvalid   <= 1'b0;
      rresp    <= EEW_RESP_OKAY;
      rdata    <= 32'h00000000;
      rd_addr  <= 8'h00;
    end
    else
    begin
      rd_stb_q <= 1'b0;
      if (arvalid && arready)
      begin
        rd_addr  <= araddr;
        arready  <= 1'b0;
        rd_stb_q <= 1'b1;
      end
      if (rd_stb_q)
      begin
        rvalid <= 1'b1;
        rdata  <= rd_data;
        rresp  <= rd_ok ? EEW_RESP_OKAY : EEW_RESP_SLVERR;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule : eew_axil

// File: logic/eew_sync.sv
// two-flop synchroniser for a bundle of pin inputs
// assumes multi-bit groups are held stable around their strobe
`timescale 1ns/1ps
module eew_sync
  import eew_pkg::*;
#(
  parameter int W = 1
)(
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_q;

  // first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge sys_clk)
      begin
        if (sys_rst)
        begin
          meta_q[i] <= 1'b0;
          q[i]      <= 1'b0;
        end
        else
        begin
          meta_q[i] <= d[i];
          q[i]      <= meta_q[i];
        end
      end
    end
  endgenerate

endmodule : eew_sync

// File: logic/eew_top.sv
// data EEPROM write guard: register file, unlock keys, timed write
// assumes an AXI4-Lite master on sys_clk and asynchronous pin inputs
`timescale 1ns/1ps
`include "eew_defines.svh"

module eew_top
  import eew_pkg::*;
#(
  parameter int unsigned PWRT_CYCLES  = `EEW_PWRT_CYC,
  parameter int unsigned WRITE_CYCLES = `EEW_WRT_CYC
)(
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 mclr_n_pin,
  input  wire logic                 wdt_timeout_pin,
  input  wire logic                 code_protect_pin,
  input  wire logic                 ext_req_pin,
  input  wire logic                 ext_we_pin,
  input  wire logic [`EEW_AW-1:0]   ext_addr_pin,
  input  wire logic [7:0]           ext_wdata_pin,
  output logic [7:0]                ext_rdata_q,
  output logic                      ext_ack_q,
  output logic                      ext_refused_q,
  output logic                      write_busy_q,
  output logic                      pwrt_running_q
);

  ////////////////////////////////////////////////////////////////////
  // bus front end and pin synchronisers

  localparam int SW = 5 + `EEW_AW + 8;

  logic             wr_stb;
  logic [7:0]       wr_addr;
  logic [31:0]      wr_data;
  logic [3:0]       wr_strb;
  logic [7:0]       rd_addr;
  logic [31:0]      rd_data;
  logic             wr_ok;
  logic             rd_ok;
  logic [SW-1:0]    pin_s;

  eew_axil u_axil (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_stb  (wr_stb),
    .wr_addr (wr_addr),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_ok   (wr_ok),
    .rd_addr (rd_addr),
    .rd_data (rd_data),
    .rd_ok   (rd_ok)
  );

  eew_sync #(.W(SW)) u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .d       ({mclr_n_pin, wdt_timeout_pin, code_protect_pin, ext_req_pin,
               ext_we_pin, ext_addr_pin, ext_wdata_pin}),
    .q       (pin_s)
  );

  wire             mclr_n_s   = pin_s[SW-1];
  wire             wdt_s      = pin_s[SW-2];
  wire             cp_s       = pin_s[SW-3];
  wire             ext_req_s  = pin_s[SW-4];
  wire             ext_we_s   = pin_s[SW-5];
  wire [`EEW_AW-1:0] ext_addr_s = pin_s[8 +: `EEW_AW];
  wire [7:0]       ext_wdata_s = pin_s[7:0];

  ////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]         mem_q [0:(1<<`EEW_AW)-1];
  logic [1:0]         addr_hi_q;
  logic [7:0]         addr_lo_q;
  logic [7:0]         data_q;
  logic               msel_q;
  logic               cfg_sel_q;
  logic               free_q;
  logic               werr_q;
  logic               wr_en_q;
  logic               rd_q;
  logic               done_flag_q;
  logic               done_en_q;
  logic               done_prio_q;
  eew_unlock_t        unlk_q;
  eew_unlock_t        unlk_d;
  logic [23:0]        wcnt_q;
  logic [23:0]        pcnt_q;
  logic               ext_req_d1_q;

  ////////////////////////////////////////////////////////////////////
  // decode: only the low byte lane carries register data

  wire lane0    = wr_stb & wr_strb[0];
  wire hit_ahi  = lane0 & (wr_addr == `EEW_OFS_ADDR_HI);
  wire hit_alo  = lane0 & (wr_addr == `EEW_OFS_ADDR_LO);
  wire hit_dat  = lane0 & (wr_addr == `EEW_OFS_DATA);
  wire hit_key  = lane0 & (wr_addr == `EEW_OFS_KEY);
  wire hit_ctl  = lane0 & (wr_addr == `EEW_OFS_CTRL);
  wire hit_flg  = lane0 & (wr_addr == `EEW_OFS_FLAGS);
  wire hit_ena  = lane0 & (wr_addr == `EEW_OFS_ENABLES);
  wire hit_pri  = lane0 & (wr_addr == `EEW_OFS_PRIO);
  wire [7:0] wb = wr_data[7:0];

  wire [`EEW_AW-1:0] ee_addr = {addr_hi_q, addr_lo_q};
  // master clear is active low on the pin; watchdog is a level
  wire soft_rst  = ~mclr_n_s | wdt_s;
  wire busy      = write_busy_q;
  wire pwrt_done = ~pwrt_running_q;
  // locked while a write runs or a reset holds the registers
  wire reg_open  = ~busy & ~soft_rst;
  // enable taken from the stored bit, so setting both in one write fails
  wire start_wr  = hit_ctl & wb[`EEW_CTL_WR] & wr_en_q
                 & (unlk_q == EEW_UNLK_ARMED)
                 & pwrt_done & reg_open
                 & ~msel_q & ~cfg_sel_q;
  wire wr_end    = busy & (wcnt_q == 24'(WRITE_CYCLES - 1));
  wire ext_rise  = ext_req_s & ~ext_req_d1_q;
  // core traffic never looks at code protect
  wire ext_allow = ~cp_s & ~busy;

  wire [7:0] ctl_rd = {msel_q, cfg_sel_q, 1'b0, free_q,
                       werr_q, wr_en_q, busy, rd_q};

  ////////////////////////////////////////////////////////////////////
  // read mux; key register reads zero, unused bits zero

  assign rd_ok = (rd_addr[7:5] == 3'b000) & (rd_addr[1:0] == 2'b00);
  assign wr_ok = (wr_addr[7:5] == 3'b000) & (wr_addr[1:0] == 2'b00);
  assign rd_data =
      (rd_addr == `EEW_OFS_ADDR_HI) ? {30'h0, addr_hi_q} :
      (rd_addr == `EEW_OFS_ADDR_LO) ? {24'h0, addr_lo_q} :
      (rd_addr == `EEW_OFS_DATA)    ? {24'h0, data_q} :
      (rd_addr == `EEW_OFS_CTRL)    ? {24'h0, ctl_rd} :
      (rd_addr == `EEW_OFS_FLAGS)   ? {27'h0, done_flag_q, 4'h0} :
      (rd_addr == `EEW_OFS_ENABLES) ? {27'h0, done_en_q, 4'h0} :
      (rd_addr == `EEW_OFS_PRIO)    ? {27'h0, done_prio_q, 4'h0} :
      32'h00000000;

  ////////////////////////////////////////////////////////////////////
  // unlock tracker: 55h, AAh, then the control write, no other bus write between

  always_comb
  begin
    unlk_d = unlk_q;
    if (soft_rst)
      unlk_d = EEW_UNLK_IDLE;
    else if (hit_key)
    begin
      if (unlk_q == EEW_UNLK_IDLE && wb == `EEW_KEY_FIRST)
        unlk_d = EEW_UNLK_GOT1;
      else if (unlk_q == EEW_UNLK_GOT1 && wb == `EEW_KEY_SECOND)
        unlk_d = EEW_UNLK_ARMED;
      else
        unlk_d = EEW_UNLK_IDLE;
    end
    else if (wr_stb)
      unlk_d = EEW_UNLK_IDLE;
  end

  // tracker register; a key byte is never stored
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      unlk_q <= EEW_UNLK_IDLE;
    else
      unlk_q <= unlk_d;
  end

  ////////////////////////////////////////////////////////////////////
  // address and data registers; reset pins force them to zero

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst)
    begin
      addr_hi_q <= 2'b00;
      addr_lo_q <= `EEW_RST_BYTE;
      data_q    <= `EEW_RST_BYTE;
    end
    else
    begin
      if (hit_ahi && reg_open)
        addr_hi_q <= wb[1:0];
      if (hit_alo && reg_open)
        addr_lo_q <= wb;
      if (rd_q)
        data_q <= mem_q[ee_addr];
      else if (hit_dat && reg_open)
        data_q <= wb;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // control bits; start bits only set here, cleared by hardware

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      msel_q       <= 1'b0;
      cfg_sel_q    <= 1'b0;
      free_q       <= 1'b0;
      werr_q       <= 1'b0;
      wr_en_q      <= 1'b0;
      rd_q         <= 1'b0;
      write_busy_q <= 1'b0;
    end
    else if (soft_rst)
    begin
      // a write cut short leaves the error flag for software
      werr_q       <= werr_q | busy;
      free_q       <= 1'b0;
      wr_en_q      <= 1'b0;
      rd_q         <= 1'b0;
      write_busy_q <= 1'b0;
    end
    else
    begin
      if (hit_ctl && reg_open)
      begin
        msel_q    <= wb[`EEW_CTL_MSEL];
        cfg_sel_q <= wb[`EEW_CTL_CFG_SEL];
        free_q    <= wb[`EEW_CTL_FREE];
        werr_q    <= wb[`EEW_CTL_WERR];
        wr_en_q   <= wb[`EEW_CTL_WR_EN];
      end
      // read of the data array only; flash space is not served here
      if (rd_q)
        rd_q <= 1'b0;
      else if (hit_ctl && reg_open && wb[`EEW_CTL_RD] && !msel_q && !cfg_sel_q)
        rd_q <= 1'b1;
      if (start_wr)
        write_busy_q <= 1'b1;
      else if (wr_end)
        write_busy_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // self-timed write and power-up timer

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst || !busy)
      wcnt_q <= 24'h000000;
    else
      wcnt_q <= wcnt_q + 24'h000001;
  end

  // runs only after a power-on reset; other resets leave it alone
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      pcnt_q         <= 24'h000000;
      pwrt_running_q <= 1'b1;
    end
    else if (pwrt_running_q)
    begin
      pcnt_q <= pcnt_q + 24'h000001;
      if (pcnt_q == 24'(PWRT_CYCLES - 1))
        pwrt_running_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt flag, enable and priority registers

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || soft_rst)
    begin
      done_flag_q <= 1'b0;
      done_en_q   <= 1'b0;
    end
    else
    begin
      // set wins over a clear in the same cycle
      if (wr_end)
        done_flag_q <= 1'b1;
      else if (hit_flg)
        done_flag_q <= wb[`EEW_IRQ_DONE];
      if (hit_ena)
        done_en_q <= wb[`EEW_IRQ_DONE];
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      done_prio_q <= `EEW_RST_PRIO;
    else if (hit_pri)
      done_prio_q <= wb[`EEW_IRQ_DONE];
  end

  ////////////////////////////////////////////////////////////////////
  // array: core write at end of timed cycle, external port when idle

  always_ff @(posedge sys_clk)
  begin
    if (wr_end && !soft_rst)
      mem_q[ee_addr] <= data_q;
    else if (ext_rise && ext_we_s && ext_allow && !soft_rst)
      mem_q[ext_addr_s] <= ext_wdata_s;
  end

  // external programming answers; blocked requests return zero
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      ext_req_d1_q  <= 1'b0;
      ext_ack_q     <= 1'b0;
      ext_refused_q <= 1'b0;
      ext_rdata_q   <= 8'h00;
    end
    else
    begin
      ext_req_d1_q <= ext_req_s;
      ext_ack_q    <= ext_rise;
      if (ext_rise)
      begin
        ext_refused_q <= ~ext_allow;
        ext_rdata_q   <= (ext_allow && !ext_we_s) ? mem_q[ext_addr_s] : 8'h00;
      end
    end
  end

endmodule : eew_top

// File: pkg/eew_defines.svh
// register offsets, field positions, reset values and timing counts
// assumes a 125 MHz core clock and an 8-bit AXI4-Lite byte address
`ifndef EEW_DEFINES_SVH
`define EEW_DEFINES_SVH

// register map, one aligned word each
`define EEW_OFS_ADDR_HI   8'h00
`define EEW_OFS_ADDR_LO   8'h04
`define EEW_OFS_DATA      8'h08
`define EEW_OFS_KEY       8'h0C
`define EEW_OFS_CTRL      8'h10
`define EEW_OFS_FLAGS     8'h14
`define EEW_OFS_ENABLES   8'h18
`define EEW_OFS_PRIO      8'h1C

// control register fields
`define EEW_CTL_MSEL      7
`define EEW_CTL_CFG_SEL   6
`define EEW_CTL_FREE      4
`define EEW_CTL_WERR      3
`define EEW_CTL_WR_EN     2
`define EEW_CTL_WR        1
`define EEW_CTL_RD        0
// write-complete bit in flags, enables and priorities
`define EEW_IRQ_DONE      4

// reset values
`define EEW_RST_BYTE      8'h00
`define EEW_RST_PRIO      1'b1

// unlock key values
`define EEW_KEY_FIRST     8'h55
`define EEW_KEY_SECOND    8'hAA

// array geometry
`define EEW_AW            10

// timing: clock period and nominal times, in ns
`define EEW_CLK_NS        8
`define EEW_PWRT_NS       72000000
`define EEW_WRT_NS        4000000
`define EEW_PWRT_CYC      (`EEW_PWRT_NS / `EEW_CLK_NS)
`define EEW_WRT_CYC       (`EEW_WRT_NS / `EEW_CLK_NS)

`endif

// File: pkg/eew_pkg.sv
// types shared by the data EEPROM write guard
// assumes eew_defines.svh for all numeric constants
package eew_pkg;

  // unlock tracker states
  typedef enum logic [1:0] {
    EEW_UNLK_IDLE  = 2'b00,
    EEW_UNLK_GOT1  = 2'b01,
    EEW_UNLK_ARMED = 2'b10
  } eew_unlock_t;

  // AXI response codes
  typedef enum logic [1:0] {
    EEW_RESP_OKAY   = 2'b00,
    EEW_RESP_SLVERR = 2'b10
  } eew_resp_t;

endpackage : eew_pkg

// File: test/eew_chk.sv
// assertions on the write guard top ports
// assumes one clock domain, bound from the bench top
`timescale 1ns/1ps
module eew_chk
#(
  parameter int unsigned WRITE_CYCLES = 10
)(
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  input wire logic       ext_req_pin,
  input wire logic [7:0] ext_rdata_q,
  input wire logic       ext_ack_q,
  input wire logic       ext_refused_q,
  input wire logic       write_busy_q,
  input wire logic       pwrt_running_q
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // busy cycle count; an overlong write would otherwise pass unseen
  int unsigned busy_n_q;
  always_ff @(posedge sys_clk)
    busy_n_q <= (sys_rst || !write_busy_q) ? 0 : busy_n_q + 1;
  // both write channels taken on one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_busy_8;
    write_busy_q [*8];
  endsequence
  property p_busy_min; $rose(write_busy_q) |-> s_busy_8; endproperty
  a_busy_min: assert property (p_busy_min) else $error("write too short");
  property p_busy_max; write_busy_q |-> busy_n_q < WRITE_CYCLES; endproperty
  a_busy_max: assert property (p_busy_max) else $error("write too long");
  property p_pwrt; $rose(write_busy_q) |-> !$past(pwrt_running_q); endproperty
  a_pwrt: assert property (p_pwrt) else $error("write under power-up timer");
  property p_bresp; s_wr_take |-> ##[1:4] s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rresp; s_axi_arvalid && s_axi_arready |-> ##[1:4] s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("read response late");
  property p_ack; $rose(ext_req_pin) |-> ##[1:5] ext_ack_q; endproperty
  a_ack: assert property (p_ack) else $error("external ack missing");
  property p_ack1; ext_ack_q |=> !ext_ack_q; endproperty
  a_ack1: assert property (p_ack1) else $error("external ack too long");
  property p_refuse; ext_ack_q && ext_refused_q |-> ext_rdata_q == 8'h00; endproperty
  a_refuse: assert property (p_refuse) else $error("refused access leaks data");
endmodule : eew_chk

// File: test/eew_top_test.sv
// self-checking bench for the data EEPROM write guard
// assumes checker and design compiled first, defines on the path
`timescale 1ns/1ps
`include "eew_defines.svh"
module eew_top_test;
  localparam logic [7:0] AH = `EEW_OFS_ADDR_HI, AL = `EEW_OFS_ADDR_LO, DA = `EEW_OFS_DATA;
  localparam logic [7:0] KY = `EEW_OFS_KEY, CT = `EEW_OFS_CTRL, FL = `EEW_OFS_FLAGS;
  localparam logic [7:0] WE = 8'h01 << `EEW_CTL_WR_EN, WR = 8'h01 << `EEW_CTL_WR;
  localparam logic [7:0] RD = 8'h01 << `EEW_CTL_RD, ER = 8'h01 << `EEW_CTL_WERR;
  localparam logic [7:0] DN = 8'h01 << `EEW_IRQ_DONE, K1 = `EEW_KEY_FIRST;
  localparam logic [7:0] K2 = `EEW_KEY_SECOND;
  logic        sys_clk = 1'b0, sys_rst = 1'b1;
  logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, ext_wdata_pin = '0, ext_rdata_q, db;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
  logic        s_axi_arvalid = '0, s_axi_rready = '0, ext_req_pin = '0, ext_we_pin = '0;
  logic        mclr_n_pin = 1'b1, wdt_timeout_pin = '0, code_protect_pin = '0;
  logic [9:0]  ext_addr_pin = '0, ad;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        ext_ack_q, ext_refused_q, write_busy_q, pwrt_running_q;
  logic [7:0]  mem [int];
  int          fails = 0, compares = 0, cyc = 0, seed = 32'hC903F062;
  // short timer counts keep the run brief
  eew_top #(.PWRT_CYCLES(150), .WRITE_CYCLES(60)) u_dut (
    .sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .mclr_n_pin, .wdt_timeout_pin, .code_protect_pin,
    .ext_req_pin, .ext_we_pin, .ext_addr_pin, .ext_wdata_pin, .ext_rdata_q, .ext_ack_q,
    .ext_refused_q, .write_busy_q, .pwrt_running_q
  );
  always #4 sys_clk = ~sys_clk;
  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("fails %0d compares %0d", fails, compares);
    if (fails == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : tally_and_finish
  // hang guard, far above the expected run
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // bus write; each channel let go on its own handshake
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
    bit aw;
    bit w;
    aw = 1'b1;
    w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge sys_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    while (aw || w);
    do
      @(posedge sys_clk);
    while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er = 2'h0);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
      @(posedge sys_clk);
    while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge sys_clk);
    while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata, {24'h0, e});
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask : rd
  task automatic keys(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    // three writes back to back, nothing may slip in between
    wr(KY, k1);
    wr(KY, k2);
    wr(CT, c);
  endtask : keys
  // external access at address ad, result seen with the ack pulse
  task automatic ext(input logic we, input logic [7:0] d, input logic [7:0] e, input logic rf);
    ext_we_pin <= we;
    ext_addr_pin <= ad;
    ext_wdata_pin <= d;
    ext_req_pin <= 1'b1;
    do
      @(posedge sys_clk);
    while (!ext_ack_q);
    chk({24'h0, ext_rdata_q}, {24'h0, e});
    chk({31'h0, ext_refused_q}, {31'h0, rf});
    ext_req_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask : ext
  ////////////////////////////////////////
  initial
  begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge sys_clk);
    // reset map, unmapped and misaligned places
    for (int i = 0; i < 8; i++)
      rd(8'(i * 4), (i == 7) ? DN : 8'h0);
    rd(8'h20, 8'h0, 2'h2);
    wr(8'h02, 8'h01, 2'h2);
    // start while the power-up timer runs
    wr(CT, WE);
    keys(K1, K2, WE | WR);
    chk({31'h0, pwrt_running_q}, 32'h1);
    rd(CT, WE);
    while (pwrt_running_q)
      @(posedge sys_clk);
    // no prior enable, enable in same write, wrong key order, stray write
    wr(CT, 8'h0);
    keys(K1, K2, WR);
    rd(CT, 8'h0);
    keys(K1, K2, WE | WR);
    rd(CT, WE);
    keys(K2, K1, WE | WR);
    rd(CT, WE);
    wr(KY, K1);
    wr(DA, 8'h5A);
    wr(KY, K2);
    wr(CT, WE | WR);
    rd(CT, WE);
    // real write at a random place, registers locked meanwhile
    ad = 10'($random(seed));
    db = 8'($random(seed));
    wr(AH, {6'h3F, ad[9:8]});
    wr(AL, ad[7:0]);
    wr(DA, db);
    keys(K1, K2, WE | WR);
    chk({31'h0, write_busy_q}, 32'h1);
    wr(DA, ~db);
    wr(AH, 8'h0);
    wr(CT, 8'h0);
    rd(DA, db);
    rd(AH, {6'h0, ad[9:8]});
    rd(CT, WE | WR);
    rd(KY, 8'h0);
    while (write_busy_q)
      @(posedge sys_clk);
    mem[ad] = db;
    rd(CT, WE);
    rd(FL, DN);
    wr(CT, 8'h0);
    rd(CT, 8'h0);
    repeat (30) @(posedge sys_clk);
    rd(FL, DN);
    wr(FL, 8'h0);
    rd(FL, 8'h0);
    // core read open while the external side is protected
    code_protect_pin <= 1'b1;
    wr(DA, 8'h0);
    wr(CT, WE | RD);
    rd(DA, mem[ad]);
    rd(CT, WE);
    ext(1'b0, 8'h0, 8'h0, 1'b1);
    ext(1'b1, ~db, 8'h0, 1'b1);
    code_protect_pin <= 1'b0;
    repeat (4) @(posedge sys_clk);
    ext(1'b0, 8'h0, mem[ad], 1'b0);
    // master clear, then watchdog, in mid-write: aborted, error flagged
    for (int k = 0; k < 2; k++)
    begin
      wr(CT, WE);
      wr(DA, ~db);
      keys(K1, K2, WE | WR);
      chk({31'h0, write_busy_q}, 32'h1);
      repeat (10) @(posedge sys_clk);
      if (k == 0)
        mclr_n_pin <= 1'b0;
      else
        wdt_timeout_pin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      mclr_n_pin <= 1'b1;
      wdt_timeout_pin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(CT, ER);
      rd(DA, 8'h0);
      ext(1'b0, 8'h0, mem[ad], 1'b0);
    end
    tally_and_finish();
  end
endmodule : eew_top_test
// checker beside the design top, write count handed on
bind eew_top eew_chk #(.WRITE_CYCLES(WRITE_CYCLES)) u_chk (
  .sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .ext_req_pin, .ext_rdata_q, .ext_ack_q, .ext_refused_q, .write_busy_q,
  .pwrt_running_q
);
